// ---- bench/tb.sv ----
// Testbench for the write-back cache controller.
// Assumes the package, the design, its checker and the media model are compiled first.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk, i_srst, i_reset_req, i_cmd_valid, i_host_sector, i_psel, i_penable;
  logic i_pwrite, i_media_done, i_media_err, i_media_realloc, o_pready, o_pslverr;
  logic o_cmd_ready, o_irq_ok, o_irq_err, o_host_xfer, o_media_rd, o_reset_ack, mbusy;
  logic rerr, got_ok, got_err, saw_rd, saw_merr, ack_seen, ack_busy;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic [1:0]  mmode;
  logic [15:0] o_host_side_buffer_pointer, o_media_side_buffer_pointer;
  wbc_pkg::wbc_cmd_s   i_cmd;
  wbc_pkg::wbc_media_s o_media_wr, mw_q;
  int bad_count, tests_run, cyc, mwritten;
  wbc_ctrl i_dut (.i_sys_clk, .i_srst, .i_reset_req, .i_cmd_valid, .i_cmd, .i_host_sector,
    .i_media_done, .i_media_err, .i_media_realloc, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_pready, .o_prdata, .o_pslverr, .o_cmd_ready, .o_irq_ok, .o_irq_err,
    .o_host_xfer, .o_host_side_buffer_pointer, .o_media_side_buffer_pointer, .o_media_wr,
    .o_media_rd, .o_reset_ack);
  wbc_media_model i_media (.i_sys_clk, .i_srst, .i_wr(o_media_wr), .i_mode(mmode),
    .o_done(i_media_done), .o_err(i_media_err), .o_realloc(i_media_realloc),
    .o_busy(mbusy), .o_written(mwritten));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    do @(posedge i_sys_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    rerr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task automatic cmd(input wbc_pkg::wbc_cmd_e op, input logic [27:0] lba, input logic [7:0] n);
    int sent;
    logic pulse;
    sent = 0;
    got_ok = 1'b0;
    got_err = 1'b0;
    @(posedge i_sys_clk);
    i_cmd_valid <= 1'b1;
    i_cmd <= '{op, lba, n, 1'b1};
    do @(posedge i_sys_clk); while (o_cmd_ready !== 1'b1);
    i_cmd_valid <= 1'b0;
    repeat (300) begin
      @(posedge i_sys_clk);
      got_ok = (o_irq_ok === 1'b1);
      got_err = (o_irq_err === 1'b1);
      pulse = (o_host_xfer === 1'b1) && (i_host_sector !== 1'b1) && (sent < int'(n));
      i_host_sector <= pulse;
      if (pulse) sent++;
      if (got_ok || got_err) break;
    end
  endtask : cmd
  // ----------------------------------------------------------------
  // Clock, monitors and sequence
  // ----------------------------------------------------------------
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    cyc++;
    if (o_media_wr.valid === 1'b1) mw_q <= o_media_wr;
    if (o_media_rd === 1'b1) saw_rd <= 1'b1;
    if (i_media_err === 1'b1) saw_merr <= 1'b1;
    if (o_reset_ack === 1'b1) ack_seen <= 1'b1;
    if (o_reset_ack === 1'b1) ack_busy <= mbusy;
    if (cyc > 20000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    {i_srst, i_reset_req, i_cmd_valid, i_host_sector, i_psel, i_penable, i_pwrite} = 7'h7F;
    {i_reset_req, i_cmd_valid, i_host_sector, i_psel, i_penable, i_pwrite} = 6'h00;
    {i_paddr, i_pwdata, i_cmd, mmode, saw_rd, saw_merr, ack_seen, ack_busy} = '0;
    repeat (6) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    apb(1'b0, wbc_pkg::ADDR_CTRL, 32'h0);
    check(rd, {30'h0, wbc_pkg::RST_RCE, wbc_pkg::RST_WCE});
    apb(1'b0, 12'h014, 32'h0);
    check({31'h0, rerr}, 32'h1);
    // Three back-to-back sequential writes; the second and third arrive while the medium is still busy.
    for (int i = 0; i < 3; i++) begin
      cmd(wbc_pkg::wbc_cmd_e'(i + 1), 28'h100 + 28'(4 * i), 8'h4);
      check({31'h0, got_ok}, 32'h1);
      check({4'h0, mw_q.lba}, 32'h100 + 32'(4 * i));
      check({31'h0, mw_q.search}, 32'(i == 0));
    end
    while (mbusy) @(posedge i_sys_clk);
    check(mwritten, 32'hC);
    saw_rd = 1'b0;
    cmd(wbc_pkg::CMD_READ, 28'h100, 8'h4);
    check({30'h0, saw_rd, got_ok}, 32'h1);
    cmd(wbc_pkg::CMD_READ, 28'h108, 8'h8);
    check({30'h0, saw_rd, got_ok}, 32'h3);
    // A failing first sector of a run; the error register then holds that sector's LBA.
    mmode <= 2'h1;
    cmd(wbc_pkg::CMD_WR_PIO, 28'h200, 8'h2);
    check({31'h0, got_ok}, 32'h1);
    while (!saw_merr) @(posedge i_sys_clk);
    mmode <= 2'h0;
    while (mbusy) @(posedge i_sys_clk);
    check(mwritten, 32'hD);
    apb(1'b0, wbc_pkg::ADDR_ERR, 32'h0);
    check(rd, 32'h200);
    cmd(wbc_pkg::CMD_READ, 28'h300, 8'h1);
    check({30'h0, got_err, got_ok}, 32'h2);
    apb(1'b0, wbc_pkg::ADDR_CTRL, 32'h0);
    check({31'h0, rd[wbc_pkg::CTRL_WCE_BIT]}, 32'h0);
    cmd(wbc_pkg::CMD_SETF, 28'h0, 8'h0);
    apb(1'b0, wbc_pkg::ADDR_CTRL, 32'h0);
    check({31'h0, rd[wbc_pkg::CTRL_WCE_BIT]}, 32'h1);
    saw_merr = 1'b0;
    mmode <= 2'h2;
    cmd(wbc_pkg::CMD_WR_DMA, 28'h300, 8'h1);
    while (!saw_merr) @(posedge i_sys_clk);
    mmode <= 2'h0;
    while (mbusy) @(posedge i_sys_clk);
    cmd(wbc_pkg::CMD_OTHER, 28'h0, 8'h0);
    check({30'h0, got_err, got_ok}, 32'h1);
    cmd(wbc_pkg::CMD_WR_PIO, 28'h500, 8'h4);
    i_reset_req <= 1'b1;
    @(posedge i_sys_clk);
    i_reset_req <= 1'b0;
    while (!ack_seen) @(posedge i_sys_clk);
    check({31'h0, ack_busy}, 32'h0);
    finish_test();
  end
endmodule : tb

// ---- bench/wbc_ctrl_checker.sv ----
// Port checker for the write-back cache controller.
// Assumes it is bound into wbc_ctrl and sees only that module's ports.
module wbc_ctrl_checker (
  input wire logic                    i_sys_clk,
  input wire logic                    i_srst,
  input wire logic                    i_cmd_valid,
  input wire logic                    i_psel,
  input wire logic                    i_penable,
  input wire logic [11:0]             i_paddr,
  input wire logic                    o_pready,
  input wire logic                    o_pslverr,
  input wire logic                    o_cmd_ready,
  input wire logic                    o_irq_ok,
  input wire logic                    o_irq_err,
  input wire logic                    o_host_xfer,
  input wire logic                    o_media_rd,
  input wire logic [wbc_pkg::PTR_W-1:0] o_host_side_buffer_pointer,
  input wire logic [wbc_pkg::PTR_W-1:0] o_media_side_buffer_pointer
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  wire unmapped = !(i_paddr inside {wbc_pkg::ADDR_CTRL, wbc_pkg::ADDR_STATUS,
                    wbc_pkg::ADDR_ERR, wbc_pkg::ADDR_LAST, wbc_pkg::ADDR_PTR});
  a_apb_ready: assert property (i_psel && i_penable |-> o_pready)
    else $error("pready missing in access phase");
  a_apb_unmapped: assert property (i_psel && i_penable && unmapped |-> o_pslverr)
    else $error("unmapped access without pslverr");
  a_irq_exclusive: assert property (!(o_irq_ok && o_irq_err))
    else $error("normal and abnormal end together");
  a_irq_pulse: assert property ((o_irq_ok || o_irq_err) |=> !(o_irq_ok || o_irq_err))
    else $error("end interrupt longer than one cycle");
  a_cmd_take: assert property (i_cmd_valid && o_cmd_ready |=> !o_cmd_ready)
    else $error("ready stayed high after a command was taken");
  a_xfer_end_irq: assert property ($fell(o_host_xfer) |-> ##[0:1] (o_irq_ok || o_irq_err))
    else $error("no end interrupt after host transfer");
  a_hit_concurrent: assert property ($rose(o_media_rd) |-> ##[0:1] o_host_xfer)
    else $error("media read without host transfer");
  a_hit_pointers: assert property ($rose(o_media_rd) |->
    ##[0:1] (o_media_side_buffer_pointer != o_host_side_buffer_pointer))
    else $error("media pointer equals host pointer on partial hit");
endmodule : wbc_ctrl_checker

bind wbc_ctrl wbc_ctrl_checker u_chk (.i_sys_clk, .i_srst, .i_cmd_valid, .i_psel, .i_penable,
  .i_paddr, .o_pready, .o_pslverr, .o_cmd_ready, .o_irq_ok, .o_irq_err, .o_host_xfer,
  .o_media_rd, .o_host_side_buffer_pointer, .o_media_side_buffer_pointer);

// ---- bench/wbc_media_model.sv ----
// Media channel model: writes the sectors of each run one after another.
// Assumes a run starts with a one-cycle valid pulse on the media write port.
module wbc_media_model #(
  parameter int SEC_GAP = 6
) (
  input  wire logic                i_sys_clk,
  input  wire logic                i_srst,
  input  wire wbc_pkg::wbc_media_s i_wr,
  input  wire logic [1:0]          i_mode,
  output logic                     o_done,
  output logic                     o_err,
  output logic                     o_realloc,
  output logic                     o_busy,
  output int                       o_written
);
  // ----------------------------------------------------------------
  // Sector engine
  // ----------------------------------------------------------------
  int  left_q;
  int  tick_q;
  wire fire = (left_q != 0) && (tick_q == SEC_GAP);
  assign o_busy = (left_q != 0);
  // A slow gap keeps the medium busy while the host sends the next command.
  always_ff @(posedge i_sys_clk) begin
    o_done    <= fire && (i_mode == 2'h0);
    o_err     <= fire && (i_mode != 2'h0);
    o_realloc <= fire && (i_mode == 2'h2);
    tick_q    <= (tick_q == SEC_GAP) ? 0 : tick_q + 1;
    left_q    <= i_srst ? 0 : left_q + (i_wr.valid ? int'(i_wr.count) : 0) - int'(fire);
    o_written <= i_srst ? 0 : o_written + int'(fire && (i_mode == 2'h0));
  end
endmodule : wbc_media_model

// ---- common/wbc_pkg.sv ----
// Package for the write-back buffer cache controller.
// Assumes one 10 MHz device clock and a synchronous active-high reset.
package wbc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_ERR    = 12'h008;
  localparam logic [11:0] ADDR_LAST   = 12'h00C;
  localparam logic [11:0] ADDR_PTR    = 12'h010;

  localparam int CTRL_WCE_BIT  = 0;
  localparam int CTRL_RCE_BIT  = 1;
  localparam int CTRL_ECLR_BIT = 2;

  localparam logic RST_WCE = 1'b1;
  localparam logic RST_RCE = 1'b1;

  localparam int LBA_W = 28;
  localparam int PTR_W = 16;
  localparam int CNT_W = 8;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_READ   = 3'b000,
    CMD_WR_PIO = 3'b001,
    CMD_WR_MUL = 3'b010,
    CMD_WR_DMA = 3'b011,
    CMD_SETF   = 3'b100,
    CMD_OTHER  = 3'b101
  } wbc_cmd_e;

  typedef struct packed {
    wbc_cmd_e           op;
    logic [LBA_W-1:0]   lba;
    logic [CNT_W-1:0]   count;
    logic               feat_wce;
  } wbc_cmd_s;

  typedef struct packed {
    logic             valid;
    logic [LBA_W-1:0] lba;
    logic [CNT_W-1:0] count;
    logic             search;
  } wbc_media_s;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RDXFER = 3'b001,
    ST_WRXFER = 3'b010,
    ST_FLUSH  = 3'b011,
    ST_DONE   = 3'b100
  } wbc_state_e;

endpackage : wbc_pkg

// ---- src/wbc_ctrl.sv ----
// Write-back buffer cache controller: partial-hit read steering and write cache.
// Assumes a host command port, a sector-granular host data port and a media
// channel that acknowledges each sector write with done or an error, with or without reallocation.
//
// Added by the designer: the register addresses and register access over APB.

module wbc_ctrl (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_srst,
  input  wire logic                      i_reset_req,
  input  wire logic                      i_cmd_valid,
  input  wire wbc_pkg::wbc_cmd_s         i_cmd,
  input  wire logic                      i_host_sector,
  input  wire logic                      i_media_done,
  input  wire logic                      i_media_err,
  input  wire logic                      i_media_realloc,
  input  wire logic                      i_psel,
  input  wire logic                      i_penable,
  input  wire logic                      i_pwrite,
  input  wire logic [11:0]               i_paddr,
  input  wire logic [31:0]               i_pwdata,
  output logic                           o_pready,
  output logic [31:0]                    o_prdata,
  output logic                           o_pslverr,
  output logic                           o_cmd_ready,
  output logic                           o_irq_ok,
  output logic                           o_irq_err,
  output logic                           o_host_xfer,
  output logic [wbc_pkg::PTR_W-1:0]      o_host_side_buffer_pointer,
  output logic [wbc_pkg::PTR_W-1:0]      o_media_side_buffer_pointer,
  output wbc_pkg::wbc_media_s            o_media_wr,
  output logic                           o_media_rd,
  output logic                           o_reset_ack
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  wbc_pkg::wbc_state_e            state_q, state_d;
  wbc_pkg::wbc_cmd_s              cur_q;
  logic                           wce_q, rce_q;
  logic                           pend_q;
  logic [wbc_pkg::LBA_W-1:0]      next_lba_q;
  logic [wbc_pkg::LBA_W-1:0]      qlba_q;
  logic [wbc_pkg::CNT_W-1:0]      qcnt_q;
  logic                           queued_q;
  logic [wbc_pkg::CNT_W-1:0]      media_left_q;
  logic [wbc_pkg::CNT_W-1:0]      host_left_q;
  logic                           err_q;
  logic [wbc_pkg::LBA_W-1:0]      err_lba_q;
  logic [wbc_pkg::LBA_W-1:0]      wr_lba_q;
  logic                           cache_vld_q;
  logic [wbc_pkg::LBA_W-1:0]      cache_lba_q;
  logic [wbc_pkg::CNT_W-1:0]      cache_cnt_q;
  logic                           rst_wait_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire is_wr = (i_cmd.op == wbc_pkg::CMD_WR_PIO) || (i_cmd.op == wbc_pkg::CMD_WR_MUL)
             || (i_cmd.op == wbc_pkg::CMD_WR_DMA);
  wire is_rd = (i_cmd.op == wbc_pkg::CMD_READ);
  wire take = i_cmd_valid && (state_q == wbc_pkg::ST_IDLE) && !rst_wait_q;
  wire media_busy = pend_q;
  wire seq_wr = (i_cmd.lba == next_lba_q);
  wire [wbc_pkg::LBA_W-1:0] cache_end = cache_lba_q + {{(wbc_pkg::LBA_W-wbc_pkg::CNT_W){1'b0}},
                                                      cache_cnt_q};
  wire hit_lead = rce_q && cache_vld_q && (i_cmd.lba >= cache_lba_q) && (i_cmd.lba < cache_end);
  wire [wbc_pkg::LBA_W-1:0] hit_span = cache_end - i_cmd.lba;
  wire full_hit = hit_lead && (hit_span >= {{(wbc_pkg::LBA_W-wbc_pkg::CNT_W){1'b0}},
                                            i_cmd.count});
  wire [wbc_pkg::CNT_W-1:0] hit_n = full_hit ? i_cmd.count : hit_span[wbc_pkg::CNT_W-1:0];
  wire media_sector = i_media_done || i_media_err;
  wire media_last = media_sector && (media_left_q == 8'h01);
  wire unrec = i_media_err && !i_media_realloc;
  wire wr_ctrl = i_psel && i_penable && i_pwrite && (i_paddr == wbc_pkg::ADDR_CTRL);
  wire host_last = i_host_sector && (host_left_q == 8'h01);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      wbc_pkg::ST_IDLE:   if (take) begin
        if (err_q && !is_wr) state_d = wbc_pkg::ST_DONE;
        else if (is_wr) state_d = wbc_pkg::ST_WRXFER;
        else if (is_rd) state_d = wbc_pkg::ST_RDXFER;
        else if (pend_q) state_d = wbc_pkg::ST_FLUSH;
        else state_d = wbc_pkg::ST_DONE;
      end
      wbc_pkg::ST_RDXFER: if (host_last) state_d = wbc_pkg::ST_DONE;
      wbc_pkg::ST_WRXFER: if (host_last) state_d = (wce_q && !err_q) ? wbc_pkg::ST_DONE
                                                  : wbc_pkg::ST_FLUSH;
      wbc_pkg::ST_FLUSH:  if (!pend_q) state_d = wbc_pkg::ST_DONE;
      wbc_pkg::ST_DONE:   state_d = wbc_pkg::ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Command flow
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_q     <= wbc_pkg::ST_IDLE;
      cur_q       <= '0;
      host_left_q <= '0;
      o_irq_ok    <= 1'b0;
      o_irq_err   <= 1'b0;
      o_host_xfer <= 1'b0;
      o_media_rd  <= 1'b0;
      o_cmd_ready <= 1'b0;
      o_host_side_buffer_pointer  <= '0;
      o_media_side_buffer_pointer <= '0;
    end else begin
      state_q     <= state_d;
      o_irq_ok    <= 1'b0;
      o_irq_err   <= 1'b0;
      o_cmd_ready <= (state_d == wbc_pkg::ST_IDLE) && !rst_wait_q;
      if (take) begin
        cur_q       <= i_cmd;
        host_left_q <= i_cmd.count;
      end else if (i_host_sector && host_left_q != '0) begin
        host_left_q <= host_left_q - 8'h01;
        o_host_side_buffer_pointer <= o_host_side_buffer_pointer + 16'h0001;
      end
      if (take && is_rd && !err_q) begin
        o_host_side_buffer_pointer  <= i_cmd.lba[wbc_pkg::PTR_W-1:0];
        o_media_side_buffer_pointer <= i_cmd.lba[wbc_pkg::PTR_W-1:0]
                                       + {8'h00, hit_lead ? hit_n : 8'h00};
        o_media_rd  <= !full_hit;
        o_host_xfer <= 1'b1;
      end else if (take && is_wr) begin
        o_host_xfer <= 1'b1;
      end else if (host_last) begin
        o_host_xfer <= 1'b0;
        o_media_rd  <= 1'b0;
      end
      if (state_q == wbc_pkg::ST_DONE) begin
        if (err_q && !(is_wr_cur(cur_q.op) && !pend_q && 1'b0)) o_irq_err <= 1'b1;
        else o_irq_ok <= 1'b1;
      end
    end
  end

  function automatic logic is_wr_cur(input wbc_pkg::wbc_cmd_e op);
    is_wr_cur = (op == wbc_pkg::CMD_WR_PIO) || (op == wbc_pkg::CMD_WR_MUL)
              || (op == wbc_pkg::CMD_WR_DMA);
  endfunction : is_wr_cur

  // ----------------------------------------------------------------
  // Background media writer
  // ----------------------------------------------------------------
  // A single queued write is held while the medium is busy; chaining a
  // sequential one extends the running count and sends the channel a non-search write.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      pend_q       <= 1'b0;
      media_left_q <= '0;
      next_lba_q   <= '0;
      queued_q     <= 1'b0;
      qlba_q       <= '0;
      qcnt_q       <= '0;
      wr_lba_q     <= '0;
      o_media_wr   <= '0;
    end else begin
      o_media_wr.valid <= 1'b0;
      if (media_sector && media_left_q != '0) begin
        media_left_q    <= media_left_q - 8'h01;
        wr_lba_q        <= wr_lba_q + 28'h0000001;
        if (media_last && !queued_q) pend_q <= 1'b0;
      end
      if (media_last && queued_q) begin
        queued_q         <= 1'b0;
        media_left_q     <= qcnt_q;
        o_media_wr.valid <= 1'b1;
        o_media_wr.lba   <= qlba_q;
        wr_lba_q         <= qlba_q;
        o_media_wr.count <= qcnt_q;
        o_media_wr.search <= 1'b1;
      end
      if (take && is_wr) begin
        next_lba_q <= i_cmd.lba + {{(wbc_pkg::LBA_W-wbc_pkg::CNT_W){1'b0}}, i_cmd.count};
        if (media_busy && seq_wr && !queued_q && !media_last) begin
          media_left_q     <= media_left_q - (media_sector ? 8'h01 : 8'h00)
                              + i_cmd.count;
          // The channel must hear of the extension, or it stops after the old run.
          o_media_wr.valid  <= 1'b1;
          o_media_wr.lba    <= i_cmd.lba;
          o_media_wr.count  <= i_cmd.count;
          o_media_wr.search <= 1'b0;
        end else if (media_busy) begin
          queued_q <= 1'b1;
          qlba_q   <= i_cmd.lba;
          qcnt_q   <= i_cmd.count;
        end else begin
          pend_q            <= 1'b1;
          media_left_q      <= i_cmd.count;
          o_media_wr.valid  <= 1'b1;
          o_media_wr.lba    <= i_cmd.lba;
          wr_lba_q          <= i_cmd.lba;
          o_media_wr.count  <= i_cmd.count;
          o_media_wr.search <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Cache state, errors and reset gating
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      wce_q       <= wbc_pkg::RST_WCE;
      rce_q       <= wbc_pkg::RST_RCE;
      err_q       <= 1'b0;
      err_lba_q   <= '0;
      cache_vld_q <= 1'b0;
      cache_lba_q <= '0;
      cache_cnt_q <= '0;
      rst_wait_q  <= 1'b0;
      o_reset_ack <= 1'b0;
    end else begin
      o_reset_ack <= 1'b0;
      if (i_reset_req) rst_wait_q <= 1'b1;
      if (rst_wait_q && !pend_q && state_q == wbc_pkg::ST_IDLE) begin
        rst_wait_q  <= 1'b0;
        o_reset_ack <= 1'b1;
        cache_vld_q <= 1'b0;
      end
      if (take && is_wr) begin
        cache_vld_q <= 1'b1;
        if (cache_vld_q && i_cmd.lba == cache_end) begin
          cache_cnt_q <= cache_cnt_q + i_cmd.count;
        end else begin
          cache_lba_q <= i_cmd.lba;
          cache_cnt_q <= i_cmd.count;
        end
      end else if (take && !is_rd) begin
        cache_vld_q <= 1'b0;
      end
      if (take && i_cmd.op == wbc_pkg::CMD_SETF) begin
        wce_q <= i_cmd.feat_wce;
        if (!i_cmd.feat_wce) cache_vld_q <= 1'b0;
      end
      if (wr_ctrl) begin
        wce_q <= i_pwdata[wbc_pkg::CTRL_WCE_BIT];
        rce_q <= i_pwdata[wbc_pkg::CTRL_RCE_BIT];
        if (!i_pwdata[wbc_pkg::CTRL_RCE_BIT]) cache_vld_q <= 1'b0;
      end
      if (state_q == wbc_pkg::ST_DONE && err_q) begin
        err_q       <= 1'b0;
        cache_vld_q <= 1'b0;
      end
      if (wr_ctrl && i_pwdata[wbc_pkg::CTRL_ECLR_BIT]) err_q <= 1'b0;
      if (unrec && media_left_q != '0) begin
        err_q     <= 1'b1;
        err_lba_q <= wr_lba_q;
        wce_q     <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  wire [31:0] rd_mux =
    (i_paddr == wbc_pkg::ADDR_CTRL)   ? {30'h0, rce_q, wce_q} :
    (i_paddr == wbc_pkg::ADDR_STATUS) ? {25'h0, queued_q, rst_wait_q, cache_vld_q,
                                         err_q, pend_q, state_q[1:0]} :
    (i_paddr == wbc_pkg::ADDR_ERR)    ? {4'h0, err_lba_q} :
    (i_paddr == wbc_pkg::ADDR_LAST)   ? {4'h0, next_lba_q} :
    (i_paddr == wbc_pkg::ADDR_PTR)    ? {o_media_side_buffer_pointer,
                                         o_host_side_buffer_pointer} : 32'h0;
  wire addr_ok = (i_paddr == wbc_pkg::ADDR_CTRL) || (i_paddr == wbc_pkg::ADDR_STATUS)
              || (i_paddr == wbc_pkg::ADDR_ERR) || (i_paddr == wbc_pkg::ADDR_LAST)
              || (i_paddr == wbc_pkg::ADDR_PTR);

  // Ready follows one cycle after setup, giving a fixed two-cycle transfer.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_pready  <= 1'b0;
      o_prdata  <= '0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel && !i_penable;
      o_prdata  <= rd_mux;
      o_pslverr <= i_psel && !i_penable && !addr_ok;
    end
  end

endmodule : wbc_ctrl
